// ==== lacm_pkg.sv ====
package lacm_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_FIRST_LEFT_LINE  = 8'h13;
  localparam logic [7:0] OFS_SECOND_LEFT_LINE = 8'h14;
  localparam logic [7:0] OFS_FIRST_RIGHT_LINE = 8'h15;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_DIFF     = 7;
  localparam int LVL_MSB      = 6;
  localparam int LVL_LSB      = 3;
  localparam int BIT_POWER    = 2;
  localparam int BIT_BIAS     = 2;
  localparam int STEP_MSB     = 1;
  localparam int STEP_LSB     = 0;

  // Writable bit masks; reserved low bits read as zero
  localparam logic [7:0] MASK_FIRST_LEFT  = 8'hff;
  localparam logic [7:0] MASK_SECOND_LEFT = 8'hfc;
  localparam logic [7:0] MASK_FIRST_RIGHT = 8'hf8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_FIRST_LEFT  = 8'h78;
  localparam logic [7:0] RST_SECOND_LEFT = 8'h78;
  localparam logic [7:0] RST_FIRST_RIGHT = 8'h78;
  localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

  // ------------------------------------------------------------
  // Level codes and soft-step rates
  // ------------------------------------------------------------
  localparam logic [3:0] LVL_MAX_VALID  = 4'h8;
  localparam logic [3:0] LVL_DISCONNECT = 4'hf;
  localparam logic [1:0] STEP_EVERY_FS  = 2'h0;
  localparam logic [1:0] STEP_EVERY_2FS = 2'h1;

  // Number of inputs mixed into the left gain stage
  localparam int NUM_INPUTS = 3;

endpackage

// ==== lacm_fs_tick.sv ====
`timescale 1ns/10ps

// Turns the asynchronous sample-rate pin into a one-cycle step tick
module lacm_fs_tick (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Sample-rate pin, not on core_clk
  input  wire logic       fs_pin,
  // Soft-step rate code
  input  wire logic [1:0] rate_sel,
  // One-cycle step strobe
  output logic            step_tick_r
);

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic level_r;
  logic half_r;
  logic rise;

  // ------------------------------------------------------------
  // Synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end
    else
    begin
      sync1_r <= fs_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A change is accepted only once the second and third stages agree
  assign rise = (sync2_r == sync3_r) && sync3_r && !level_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      level_r <= 1'b0;
    else if (sync2_r == sync3_r)
      level_r <= sync3_r;
  end

  // ------------------------------------------------------------
  // Rate divider
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      half_r <= 1'b0;
    else if (rise)
      half_r <= ~half_r;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      step_tick_r <= 1'b0;
    else if (rate_sel == lacm_pkg::STEP_EVERY_FS)
      step_tick_r <= rise;
    else if (rate_sel == lacm_pkg::STEP_EVERY_2FS)
      step_tick_r <= rise && half_r;
    else
      step_tick_r <= 1'b0;
  end

  a_tick_disabled: assert property (@(posedge core_clk) disable iff (!nrst)
    rate_sel[1] |=> !step_tick_r)
    else $error("step tick while soft-stepping disabled");

  a_tick_single: assert property (@(posedge core_clk) disable iff (!nrst)
    step_tick_r |=> !step_tick_r)
    else $error("step tick longer than one cycle");

endmodule

// ==== lacm_gain_stepper.sv ====
`timescale 1ns/10ps

// Tracks one input's applied mix level toward its programmed code
module lacm_gain_stepper (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Programmed code and stepping control
  input  wire logic [3:0] target,
  input  wire logic       soft_en,
  input  wire logic       step_tick,
  // Applied state
  output logic [3:0]      level_r,
  output logic            connected_r
);

  logic valid;

  // Reserved codes are treated like the disconnect code
  assign valid = (target <= lacm_pkg::LVL_MAX_VALID);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      connected_r <= 1'b0;
    else
      connected_r <= valid;
  end

  // A fresh connection starts at the target; only live changes are stepped
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      level_r <= lacm_pkg::LVL_MAX_VALID;
    else if (valid)
    begin
      if (!connected_r || !soft_en)
        level_r <= target;
      else if (step_tick && (level_r < target))
        level_r <= level_r + 4'h1;
      else if (step_tick && (level_r > target))
        level_r <= level_r - 4'h1;
    end
  end

  a_step_one: assert property (@(posedge core_clk) disable iff (!nrst)
    (connected_r && valid && soft_en)
      |=> (level_r == $past(level_r)) || (level_r == $past(level_r) + 4'h1)
          || (level_r + 4'h1 == $past(level_r)))
    else $error("applied level moved more than one step");

  a_step_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (connected_r && valid && soft_en && !step_tick) |=> (level_r == $past(level_r)))
    else $error("applied level moved without a step tick");

endmodule

// ==== lacm_left_mix_cfg.sv ====
`timescale 1ns/10ps

// Notes on behaviour
// - Power bit of first-left-line register powers left ADC channel up when one.
// - Two-bit code: 00 step per fs, 01 per two fs, 10/11 no stepping.
// - Second-left-line bit 7 selects single-ended (0) or differential (1).
// - Second-left-line level codes 0..8 give 0 to -12 dB; 1111 disconnects.
// - Any valid gain code connects the input to the mix automatically.
// - Second-left-line bit 2 weakly biases unselected inputs to common mode.
// - Reserved low bits read zero, reset to zero; software writes zeros.
// - First-right-line bit 7 selects single-ended (0) or differential (1).
// - First-right-line level uses same coding; 1111 disconnects it.
// - First-left-line register also holds mode bit and four-bit level field.
module lacm_left_mix_cfg (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Register access port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_r,
  // Sample-rate pin
  input  wire logic       fs_pin,
  // Channel controls
  output logic            adc_power_on_r,
  output logic            weak_bias_en_r,
  // First left line input
  output logic            first_left_diff_r,
  output logic            first_left_connected,
  output logic [3:0]      first_left_level,
  // Second left line input
  output logic            second_left_diff_r,
  output logic            second_left_connected,
  output logic [3:0]      second_left_level,
  // First right line input
  output logic            first_right_diff_r,
  output logic            first_right_connected,
  output logic [3:0]      first_right_level
);

  logic [7:0] first_left_r;
  logic [7:0] second_left_r;
  logic [7:0] first_right_r;
  logic [1:0] step_rate;
  logic       soft_en;
  logic       step_tick;
  logic [3:0] target   [lacm_pkg::NUM_INPUTS];
  logic [3:0] level    [lacm_pkg::NUM_INPUTS];
  logic       conn     [lacm_pkg::NUM_INPUTS];

  // Read value of an offset; unmapped offsets read as zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] r0,
                                          input logic [7:0] r1,
                                          input logic [7:0] r2);
    logic [7:0] v;
    v = lacm_pkg::RDATA_UNMAPPED;
    if (addr == lacm_pkg::OFS_FIRST_LEFT_LINE)
      v = r0;
    else if (addr == lacm_pkg::OFS_SECOND_LEFT_LINE)
      v = r1 & lacm_pkg::MASK_SECOND_LEFT;
    else if (addr == lacm_pkg::OFS_FIRST_RIGHT_LINE)
      v = r2 & lacm_pkg::MASK_FIRST_RIGHT;
    return v;
  endfunction

  // Level field of a routing register
  function automatic logic [3:0] level_of(input logic [7:0] r);
    return r[lacm_pkg::LVL_MSB:lacm_pkg::LVL_LSB];
  endfunction

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Reserved codes are stored as written; the stepper treats them as
  // disconnect, so a careless write cannot leave a half-routed input.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      first_left_r <= lacm_pkg::RST_FIRST_LEFT;
    else if (reg_wr && (reg_addr == lacm_pkg::OFS_FIRST_LEFT_LINE))
      first_left_r <= reg_wdata & lacm_pkg::MASK_FIRST_LEFT;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      second_left_r <= lacm_pkg::RST_SECOND_LEFT;
    else if (reg_wr && (reg_addr == lacm_pkg::OFS_SECOND_LEFT_LINE))
      second_left_r <= reg_wdata & lacm_pkg::MASK_SECOND_LEFT;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      first_right_r <= lacm_pkg::RST_FIRST_RIGHT;
    else if (reg_wr && (reg_addr == lacm_pkg::OFS_FIRST_RIGHT_LINE))
      first_right_r <= reg_wdata & lacm_pkg::MASK_FIRST_RIGHT;
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata_r <= lacm_pkg::RDATA_UNMAPPED;
    else if (reg_rd)
      reg_rdata_r <= read_mux(reg_addr, first_left_r, second_left_r, first_right_r);
  end

  // ------------------------------------------------------------
  // Channel controls
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      adc_power_on_r <= 1'b0;
    else
      adc_power_on_r <= first_left_r[lacm_pkg::BIT_POWER];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      weak_bias_en_r <= 1'b0;
    else
      weak_bias_en_r <= second_left_r[lacm_pkg::BIT_BIAS];
  end

  // The right channel owns its own copy of each shared input's mode; this
  // block cannot see it, so matching the two is left to software.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      first_left_diff_r  <= 1'b0;
      second_left_diff_r <= 1'b0;
      first_right_diff_r <= 1'b0;
    end
    else
    begin
      first_left_diff_r  <= first_left_r[lacm_pkg::BIT_DIFF];
      second_left_diff_r <= second_left_r[lacm_pkg::BIT_DIFF];
      first_right_diff_r <= first_right_r[lacm_pkg::BIT_DIFF];
    end
  end

  // ------------------------------------------------------------
  // Soft-stepping
  // ------------------------------------------------------------
  assign step_rate = first_left_r[lacm_pkg::STEP_MSB:lacm_pkg::STEP_LSB];
  assign soft_en   = !step_rate[1];

  lacm_fs_tick u_fs_tick (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .fs_pin      (fs_pin),
    .rate_sel    (step_rate),
    .step_tick_r (step_tick)
  );

  assign target[0] = level_of(first_left_r);
  assign target[1] = level_of(second_left_r);
  assign target[2] = level_of(first_right_r);

  genvar gi;
  generate
    for (gi = 0; gi < lacm_pkg::NUM_INPUTS; gi++)
    begin : g_input
      lacm_gain_stepper u_stepper (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .target      (target[gi]),
        .soft_en     (soft_en),
        .step_tick   (step_tick),
        .level_r     (level[gi]),
        .connected_r (conn[gi])
      );
    end
  endgenerate

  assign first_left_level      = level[0];
  assign first_left_connected  = conn[0];
  assign second_left_level     = level[1];
  assign second_left_connected = conn[1];
  assign first_right_level     = level[2];
  assign first_right_connected = conn[2];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_power_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == lacm_pkg::OFS_FIRST_LEFT_LINE)
      |-> ##2 (adc_power_on_r == $past(reg_wdata[2], 2)))
    else $error("left channel power does not follow written bit");

  a_second_mode: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == lacm_pkg::OFS_SECOND_LEFT_LINE)
      |-> ##2 (second_left_diff_r == $past(reg_wdata[7], 2)))
    else $error("second left input mode does not follow written bit");

  a_right_mode: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == lacm_pkg::OFS_FIRST_RIGHT_LINE)
      |-> ##2 (first_right_diff_r == $past(reg_wdata[7], 2)))
    else $error("first right input mode does not follow written bit");

  a_bias_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == lacm_pkg::OFS_SECOND_LEFT_LINE)
      |-> ##2 (weak_bias_en_r == $past(reg_wdata[2], 2)))
    else $error("weak bias does not follow written bit");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_rd && (reg_addr == lacm_pkg::OFS_SECOND_LEFT_LINE
                || reg_addr == lacm_pkg::OFS_FIRST_RIGHT_LINE))
      |=> (reg_rdata_r[1:0] == 2'h0) && (reg_rdata_r[2] == 1'b0 || !$past(reg_addr[0])))
    else $error("reserved bits read nonzero");

  a_second_conn: assert property (@(posedge core_clk) disable iff (!nrst)
    (target[1] <= lacm_pkg::LVL_MAX_VALID) |=> second_left_connected)
    else $error("valid code did not connect second left input");

  a_second_disc: assert property (@(posedge core_clk) disable iff (!nrst)
    (target[1] == lacm_pkg::LVL_DISCONNECT) |=> !second_left_connected)
    else $error("disconnect code left second left input connected");

  a_right_conn: assert property (@(posedge core_clk) disable iff (!nrst)
    (target[2] == lacm_pkg::LVL_DISCONNECT) |=> !first_right_connected)
    else $error("disconnect code left first right input connected");

  a_left_level: assert property (@(posedge core_clk) disable iff (!nrst)
    (!soft_en && target[0] <= lacm_pkg::LVL_MAX_VALID) |=> (first_left_level == $past(target[0])))
    else $error("first left level not applied at once with stepping off");

  a_step_jump: assert property (@(posedge core_clk) disable iff (!nrst)
    (!soft_en && target[1] <= lacm_pkg::LVL_MAX_VALID) |=> (second_left_level == $past(target[1])))
    else $error("second left level stepped while stepping disabled");

  // ------------------------------------------------------------
  // Register checks
  // ------------------------------------------------------------
  // Reads must show the stored byte of the offset sampled with the strobe,
  // whatever writes came before.
  a_read_first: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == lacm_pkg::OFS_FIRST_LEFT_LINE)
      |=> (reg_rdata_r == $past(first_left_r)))
    else $error("first left read does not show stored byte");

  a_read_second: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == lacm_pkg::OFS_SECOND_LEFT_LINE)
      |=> (reg_rdata_r == $past(second_left_r)))
    else $error("second left read does not show stored byte");

  a_read_right: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == lacm_pkg::OFS_FIRST_RIGHT_LINE)
      |=> (reg_rdata_r == $past(first_right_r)))
    else $error("first right read does not show stored byte");

  a_reserved_store: assert property (@(posedge core_clk) disable iff (!nrst)
    (second_left_r[1:0] == 2'h0) && (first_right_r[2:0] == 3'h0))
    else $error("reserved bits stored nonzero");

  a_unmapped_read: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_rd && (reg_addr < lacm_pkg::OFS_FIRST_LEFT_LINE
                || reg_addr > lacm_pkg::OFS_FIRST_RIGHT_LINE))
      |=> (reg_rdata_r == lacm_pkg::RDATA_UNMAPPED))
    else $error("unmapped offset read nonzero");

  a_left_mode: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_wr && reg_addr == lacm_pkg::OFS_FIRST_LEFT_LINE)
      |-> ##2 (first_left_diff_r == $past(reg_wdata[7], 2)))
    else $error("first left input mode does not follow written bit");

  // ------------------------------------------------------------
  // Routing checks
  // ------------------------------------------------------------
  // Connection follows the code one edge later, stepping or not
  a_first_conn: assert property (@(posedge core_clk) disable iff (!nrst)
    (target[0] <= lacm_pkg::LVL_MAX_VALID)
      |=> first_left_connected)
    else $error("valid code did not connect first left input");

  a_first_disc: assert property (@(posedge core_clk) disable iff (!nrst)
    (target[0] == lacm_pkg::LVL_DISCONNECT)
      |=> !first_left_connected)
    else $error("disconnect code left first left input connected");

  a_right_valid: assert property (@(posedge core_clk) disable iff (!nrst)
    (target[2] <= lacm_pkg::LVL_MAX_VALID)
      |=> first_right_connected)
    else $error("valid code did not connect first right input");

  a_right_level: assert property (@(posedge core_clk) disable iff (!nrst)
    (!soft_en && target[2] <= lacm_pkg::LVL_MAX_VALID)
      |=> (first_right_level == $past(target[2])))
    else $error("first right level not applied at once with stepping off");

endmodule

// ==== lacm_left_mix_cfg_tb.sv ====
`timescale 1ns/10ps

module lacm_left_mix_cfg_tb;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic            core_clk;
  logic            nrst;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic            fs_pin;
  logic [7:0]      reg_rdata_r;
  logic            adc_power_on_r;
  logic            weak_bias_en_r;
  logic [2:0]      diff;
  logic [2:0]      conn;
  logic [2:0][3:0] lvl;
  logic [7:0]      shadow [3];
  logic [7:0]      rv;
  integer          seed;
  integer          fails;
  integer          checked;

  lacm_left_mix_cfg uut (
    .core_clk              (core_clk),
    .nrst                  (nrst),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata_r           (reg_rdata_r),
    .fs_pin                (fs_pin),
    .adc_power_on_r        (adc_power_on_r),
    .weak_bias_en_r        (weak_bias_en_r),
    .first_left_diff_r     (diff[0]),
    .first_left_connected  (conn[0]),
    .first_left_level      (lvl[0]),
    .second_left_diff_r    (diff[1]),
    .second_left_connected (conn[1]),
    .second_left_level     (lvl[1]),
    .first_right_diff_r    (diff[2]),
    .first_right_connected (conn[2]),
    .first_right_level     (lvl[2])
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] mask_of(input int i);
    if (i == 0)
      return lacm_pkg::MASK_FIRST_LEFT;
    if (i == 1)
      return lacm_pkg::MASK_SECOND_LEFT;
    return lacm_pkg::MASK_FIRST_RIGHT;
  endfunction

  function automatic logic [7:0] ofs_of(input int i);
    return lacm_pkg::OFS_FIRST_LEFT_LINE + 8'(i);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Derived outputs move one edge after the write edge, so wait them out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    d = reg_rdata_r;
  endtask

  // Pin is slow and synchronised inside, so each phase lasts many cycles
  task automatic fs_pulse();
    @(posedge core_clk);
    fs_pin <= 1'b1;
    repeat (12) @(posedge core_clk);
    fs_pin <= 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
  endtask

  // Valid only while soft-stepping is off, when levels jump to target
  task automatic check_outputs();
    logic [3:0] t;
    check({7'h0, adc_power_on_r}, {7'h0, shadow[0][2]});
    check({7'h0, weak_bias_en_r}, {7'h0, shadow[1][2]});
    for (int i = 0; i < 3; i++)
    begin
      t = shadow[i][6:3];
      check({7'h0, diff[i]}, {7'h0, shadow[i][7]});
      check({7'h0, conn[i]}, {7'h0, t <= 4'h8});
      if (t <= 4'h8)
        check({4'h0, lvl[i]}, {4'h0, t});
    end
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (100000) @(posedge core_clk);
    fails++;
    conclude();
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    int         i;
    int         r;
    seed      = 24;
    fails     = 0;
    checked   = 0;
    nrst      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    fs_pin    = 1'b0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;

    for (i = 0; i < 3; i++)
    begin
      rd(ofs_of(i), rv);
      check(rv, 8'h78);
      shadow[i] = 8'h78;
    end
    check_outputs();
    $display("test reset done");

    wr(8'h16, 8'hff);
    rd(8'h16, rv);
    check(rv, lacm_pkg::RDATA_UNMAPPED);
    rd(8'h12, rv);
    check(rv, lacm_pkg::RDATA_UNMAPPED);
    rd(8'h13, rv);
    check(rv, 8'h78);
    $display("test unmapped done");

    // Stepping off first, so every random write shows its target at once
    wr(8'h13, 8'h7a);
    shadow[0] = 8'h7a;
    for (int n = 0; n < 40; n++)
    begin
      i = $unsigned($random(seed)) % 3;
      r = $unsigned($random(seed)) % 10;
      d = 8'($random(seed));
      d[6:3] = (r == 9) ? 4'hf : 4'(r);
      if (i == 0)
        d[1] = 1'b1;
      if (n < 3)
        d[6:3] = 4'(n * 4);
      // Software keeps reserved bits at zero
      d = d & mask_of(i);
      wr(ofs_of(i), d);
      shadow[i] = d & mask_of(i);
      check_outputs();
      rd(ofs_of(i), rv);
      check(rv, shadow[i]);
    end
    $display("test random done");

    // Disconnect first so the next valid code is a fresh connection;
    // shared inputs stay single-ended to match the right channel's copy
    wr(8'h13, 8'h7c);
    wr(8'h14, 8'h78);
    wr(8'h14, 8'h00);
    check({4'h0, lvl[1]}, 8'h00);
    check({7'h0, conn[1]}, 8'h01);
    wr(8'h14, 8'h40);
    check({4'h0, lvl[1]}, 8'h00);
    for (int k = 1; k <= 8; k++)
    begin
      fs_pulse();
      check({4'h0, lvl[1]}, 8'(k));
    end
    $display("test step per fs done");

    wr(8'h13, 8'h7d);
    wr(8'h14, 8'h00);
    for (int k = 1; k <= 3; k++)
    begin
      fs_pulse();
      fs_pulse();
      check({4'h0, lvl[1]}, 8'(8 - k));
    end
    $display("test step per two fs done");
    conclude();
  end

endmodule
